//--- verif/logic_acquisition_module_test.sv
`timescale 1ns/10ps
module logic_acquisition_module_test;
   import acq_pkg::*;
   logic                  sys_clk, reset, tclk_pin, ext_event, run, fall;
   logic                  reg_wr, reg_rd, irq, trig_out, acq_running;
   logic [CH_N*LVL_W-1:0] ch_level;
   logic [7:0]            reg_addr;
   logic [31:0]           reg_wdata, reg_rdata, d, ta;
   logic [CH_N-1:0]       bits;
   logic [LVL_W-1:0]      thr;
   int                    errors = 0, num_checks = 0, trig_seen = 0;

   logic_acquisition_module #(.AW(8)) i_logic_acquisition_module (
      .sys_clk(sys_clk), .reset(reset), .ch_level(ch_level),
      .tclk_pin(tclk_pin), .ext_event(ext_event), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq), .trig_out(trig_out),
      .acq_running(acq_running));
   target_model #(.HALF(8)) i_target_model (
      .sys_clk(sys_clk), .bits(bits), .thr(thr), .run(run), .fall(fall),
      .ch_level(ch_level), .tclk_pin(tclk_pin));

   // Free-running 100 MHz clock.
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   // Counts trigger pulses so a second or missing trigger shows up.
   always @(posedge sys_clk) begin
      if (trig_out === 1'b1) trig_seen++;
   end

   task automatic wrap_up();
      $display("checks %0d errors %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e,
                      input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge sys_clk);
      reg_wr <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe, so grab them there.
   task automatic rd(input logic [7:0] a);
      @(posedge sys_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge sys_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   task automatic wait_state(input logic [3:0] s);
      for (int n = 0; n < 3000; n++) begin
         rd(OFF_STATUS);
         if (d[3:0] === s) return;
      end
      chk("state wait", s, d);
      wrap_up();
   endtask
   // Expected progress word once stopped: post count and write pointer.
   function automatic logic [31:0] exp_prog(input logic [7:0] t, int p);
      return {7'h00, 9'(p), 8'h00, 8'(int'(t) + p + 1)};
   endfunction

   // One acquisition: long run of non-matching data, then the hit pattern.
   task automatic trig_case(input int ten, input logic ext, input logic fe,
                            input int post);
      logic [7:0] hit;
      hit = 8'($urandom);
      thr = LVL_W'(1 + $urandom % 14);
      bits <= ~hit;
      run <= ext;
      fall <= fe;
      ext_event <= 1'b0;
      wr(OFF_THRESH, {28'h0, thr});
      wr(OFF_DIV, 32'h0);
      wr(OFF_TVAL, {16'h0, 8'hFF, hit});
      wr(OFF_TRANGE, {16'h0, hit | 8'h0F, hit});
      wr(OFF_POST, post);
      wr(OFF_IRQ_STAT, 32'h7);
      trig_seen = 0;
      // New levels may wait a whole target clock period, so let the channel
      // bits settle on the non-matching value before arming.
      repeat (20) @(posedge sys_clk);
      wr(OFF_CTRL, (ten << CTRL_TEN) | (ext << CTRL_EXT)
                   | (fe << CTRL_FALL) | 1);
      repeat (300) @(posedge sys_clk);
      rd(OFF_STATUS);
      chk("armed status", {27'h0, !ext, 4'h2}, d);
      chk("running", 1, acq_running);
      chk("early trigger", 0, trig_seen);
      rd(OFF_PROGRESS);
      chk("progress moving", 1, d[7:0] != 8'h00);
      bits <= hit;
      if (ten[TEN_EXT]) begin
         repeat (8) @(posedge sys_clk);
         ext_event <= 1'b1;
      end
      wait_state(4'h8);
      rd(OFF_TRIGADDR);
      ta = d;
      chk("trigger count", 1, trig_seen);
      chk("stopped", 0, acq_running);
      rd(OFF_PROGRESS);
      chk("final progress", exp_prog(ta[7:0], post), d);
      wr(OFF_MEM_ADDR, ta);
      rd(OFF_MEM_DATA);
      chk("trigger sample", hit, d[7:0]);
      rd(OFF_IRQ_STAT);
      chk("irq status", {29'h0, !ext, 2'h3}, d);
      chk("irq level", 1, irq);
      wr(OFF_IRQ_STAT, 32'h2);
      repeat (2) @(posedge sys_clk);
      chk("irq cleared", 0, irq);
   endtask

   initial begin
      logic [7:0]  offs [6] = '{OFF_THRESH, OFF_DIV, OFF_TCOUNT, OFF_STATUS,
                                OFF_IRQ_STAT, 8'h3C};
      logic [31:0] rsts [6] = '{32'h8, 32'h0, 32'h1, 32'h1, 32'h0, 32'h0};
      logic [31:0] ts;
      reset = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 32'h0;
      ext_event = 1'b0;
      bits = 8'h00;
      thr = 4'h8;
      run = 1'b0;
      fall = 1'b0;
      d = $urandom(30);
      repeat (5) @(posedge sys_clk);
      reset <= 1'b0;
      for (int i = 0; i < 6; i++) begin
         rd(offs[i]);
         chk("reset value", rsts[i], d);
      end
      wr(OFF_IRQ_MASK, 32'h2);
      // Value, range and external triggers, both target clock edges, then random runs.
      trig_case(1 << TEN_VAL, 1'b0, 1'b0, 5);
      trig_case(1 << TEN_RNG, 1'b0, 1'b0, 7);
      trig_case(1 << TEN_EXT, 1'b0, 1'b0, 2);
      trig_case(1 << TEN_VAL, 1'b1, 1'b0, 4);
      trig_case(1 << TEN_VAL, 1'b1, 1'b1, 3);
      for (int k = 0; k < 3; k++) begin
         trig_case(1 << ($urandom % 2), 1'b0, 1'b0, 1 + $urandom % 20);
      end
      // Counter trigger on the third slow sample, no posttrigger part.
      run <= 1'b0;
      wr(OFF_DIV, 32'h2);
      wr(OFF_TCOUNT, 32'h3);
      wr(OFF_POST, 32'h0);
      wr(OFF_CTRL, (1 << (CTRL_TEN + TEN_CNT)) | 1);
      wait_state(4'h8);
      rd(OFF_TRIGADDR);
      chk("count slot", 2, d);
      wr(OFF_MEM_ADDR, 32'h1);
      rd(OFF_MEM_DATA);
      ts = d;
      wr(OFF_MEM_ADDR, 32'h2);
      rd(OFF_MEM_DATA);
      chk("stamp step", 3, 16'(d[31:16] - ts[31:16]));
      // Qualifier modes value, range and not-value in turn: the first sample triggers, the refused
      // value stores nothing, then exactly the posttrigger samples land.
      wr(OFF_DIV, 32'h0);
      wr(OFF_TCOUNT, 32'h1);
      wr(OFF_POST, 32'h3);
      wr(OFF_TVAL, 32'hFF3C);
      wr(OFF_TRANGE, 32'h3F30);
      for (int q = 1; q < 4; q++) begin
         bits <= (q == 3) ? 8'h3C : 8'h00;
         repeat (8) @(posedge sys_clk);
         wr(OFF_CTRL, (1 << (CTRL_TEN + TEN_CNT)) | (q << CTRL_QUAL) | 1);
         repeat (30) @(posedge sys_clk);
         rd(OFF_PROGRESS);
         chk("unqualified", 0, d);
         bits <= (q == 3) ? 8'h00 : 8'h3C;
         wait_state(4'h8);
         rd(OFF_PROGRESS);
         chk("qualified", 32'h0003_0003, d);
      end
      wrap_up();
   end
endmodule

//--- verif/target_model.sv
`timescale 1ns/10ps
// Target system: turns wanted bits into level codes and runs a target clock.
module target_model
   import acq_pkg::*;
#(
   parameter int HALF = 8
) (
   input  wire logic                  sys_clk,
   input  wire logic [CH_N-1:0]       bits,
   input  wire logic [LVL_W-1:0]      thr,
   input  wire logic                  run,
   input  wire logic                  fall,
   output logic      [CH_N*LVL_W-1:0] ch_level,
   output logic                       tclk_pin
);
   int               cnt = 0;
   int               nxt;
   logic [CH_N-1:0]  last_bits = '0;
   logic [LVL_W-1:0] last_thr = '0;
   logic             upd;
   initial ch_level = '0;
   initial tclk_pin = 1'b0;
   // Outside a run levels move only when the wanted bits or the threshold move;
   // in a run they are redrawn once a period, on the edge the analyzer ignores;
   // redrawing them every cycle would never let the three-flop filter accept a word.
   always_comb begin
      nxt = (run && cnt < HALF - 1) ? cnt + 1 : 0;
      upd = run ? (nxt == 0 && tclk_pin != fall)
                : (bits != last_bits || thr != last_thr);
   end
   // Data is stable for a whole period around the sampling edge; the clock
   // rests outside a run.
   always @(posedge sys_clk) begin
      cnt       <= nxt;
      last_bits <= bits;
      last_thr  <= thr;
      if (run && nxt == 0) tclk_pin <= !tclk_pin;
      else if (!run) tclk_pin <= fall;
      // Levels are redrawn only when upd is set, equal to threshold reads as zero.
      for (int i = 0; i < CH_N; i++) begin
         if (upd) ch_level[i*LVL_W +: LVL_W] <= bits[i] ?
            LVL_W'(int'(thr) + 1 + $urandom % (15 - int'(thr))) :
            LVL_W'($urandom % (int'(thr) + 1));
      end
   end
endmodule

//--- verilog/acq_pkg.sv
package acq_pkg;

   // Sample geometry: channel count, level code width, time stamp width.
   localparam int CH_N   = 8;
   localparam int LVL_W  = 4;
   localparam int TS_W   = 16;
   localparam int MEM_AW = 8;

   // Register byte offsets on the plain register port.
   localparam logic [7:0] OFF_CTRL     = 8'h00;
   localparam logic [7:0] OFF_THRESH   = 8'h04;
   localparam logic [7:0] OFF_DIV      = 8'h08;
   localparam logic [7:0] OFF_TVAL     = 8'h0C;
   localparam logic [7:0] OFF_TRANGE   = 8'h10;
   localparam logic [7:0] OFF_TCOUNT   = 8'h14;
   localparam logic [7:0] OFF_POST     = 8'h18;
   localparam logic [7:0] OFF_STATUS   = 8'h1C;
   localparam logic [7:0] OFF_PROGRESS = 8'h20;
   localparam logic [7:0] OFF_TRIGADDR = 8'h24;
   localparam logic [7:0] OFF_IRQ_STAT = 8'h28;
   localparam logic [7:0] OFF_IRQ_MASK = 8'h2C;
   localparam logic [7:0] OFF_MEM_ADDR = 8'h30;
   localparam logic [7:0] OFF_MEM_DATA = 8'h34;

   // Control register fields.
   localparam int CTRL_START = 0;
   localparam int CTRL_EXT   = 2;
   localparam int CTRL_FALL  = 3;
   localparam int CTRL_QUAL  = 4;
   localparam int CTRL_TEN   = 6;

   // Trigger enable bits inside the four-bit enable field.
   localparam int TEN_VAL = 0;
   localparam int TEN_RNG = 1;
   localparam int TEN_EXT = 2;
   localparam int TEN_CNT = 3;

   // Field positions in packed words.
   localparam int HI_FIELD  = 8;
   localparam int PROG_POST = 16;
   localparam int STAT_WRAP = 4;
   localparam int SW_GLITCH = 8;
   localparam int SW_TS     = 16;

   // Interrupt status bits.
   localparam int IRQ_TRIG = 0;
   localparam int IRQ_DONE = 1;
   localparam int IRQ_WRAP = 2;
   localparam int IRQ_W    = 3;

   // Storage qualifier modes.
   localparam logic [1:0] QUAL_ALL  = 2'h0;
   localparam logic [1:0] QUAL_VAL  = 2'h1;
   localparam logic [1:0] QUAL_RNG  = 2'h2;
   localparam logic [1:0] QUAL_NVAL = 2'h3;

   // Reset values of software registers.
   localparam logic [LVL_W-1:0] THRESH_RST = 4'h8;
   localparam logic [15:0]      DIV_RST    = 16'h0000;
   localparam logic [15:0]      TCOUNT_RST = 16'h0001;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'h1,
      ST_ARMED = 4'h2,
      ST_POST  = 4'h4,
      ST_DONE  = 4'h8
   } acq_state_e;

endpackage

//--- verilog/input_conditioner.sv
`timescale 1ns/10ps
module input_conditioner #(
   parameter int CH = 8,
   parameter int LW = 4
) (
   input  wire logic              sys_clk,
   input  wire logic              reset,
   input  wire logic [CH*LW-1:0]  ch_level,
   input  wire logic [LW-1:0]     threshold,
   input  wire logic              tclk_pin,
   input  wire logic              edge_fall,
   output logic      [CH-1:0]     ch_bits,
   output logic                   tclk_edge
);
   typedef struct packed {
      logic [CH*LW-1:0] lvl1;
      logic [CH*LW-1:0] lvl2;
      logic [CH*LW-1:0] lvl3;
      logic [CH*LW-1:0] lvl_ok;
      logic             c1;
      logic             c2;
      logic             c3;
      logic             c_ok;
      logic [CH-1:0]    bits;
      logic             edge_p;
   } cond_s;

   cond_s s;
   cond_s next_s;

   // Pins pass three flops; a value is accepted only when stages two and
   // three agree, so a word caught mid-change is never compared.
   always_comb begin
      next_s        = s;
      next_s.lvl1   = ch_level;
      next_s.lvl2   = s.lvl1;
      next_s.lvl3   = s.lvl2;
      next_s.c1     = tclk_pin;
      next_s.c2     = s.c1;
      next_s.c3     = s.c2;
      next_s.edge_p = 1'b0;
      if (s.lvl2 == s.lvl3) begin
         next_s.lvl_ok = s.lvl3;
      end
      for (int i = 0; i < CH; i++) begin
         next_s.bits[i] = s.lvl_ok[i*LW +: LW] > threshold;
      end
      if (s.c2 == s.c3 && s.c3 != s.c_ok) begin
         next_s.c_ok   = s.c3;
         next_s.edge_p = s.c3 != edge_fall;
      end
   end

   // State register.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         s <= '0;
      end else begin
         s <= next_s;
      end
   end

   assign ch_bits   = s.bits;
   assign tclk_edge = s.edge_p;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   thresh_compare_a: assert property (
      ##1 s.bits[0] == ($past(s.lvl_ok[LW-1:0]) > $past(threshold)))
      else $error("Channel bit disagrees with threshold compare.");

   edge_select_a: assert property (
      s.edge_p |-> s.c_ok != $past(s.c_ok) && s.c_ok != $past(edge_fall))
      else $error("Target clock edge of the wrong sense.");

endmodule

//--- verilog/logic_acquisition_module.sv
`timescale 1ns/10ps
module logic_acquisition_module
   import acq_pkg::*;
#(
   parameter int AW = acq_pkg::MEM_AW
) (
   input  wire logic                              sys_clk,
   input  wire logic                              reset,
   input  wire logic [acq_pkg::CH_N*acq_pkg::LVL_W-1:0] ch_level,
   input  wire logic                              tclk_pin,
   input  wire logic                              ext_event,
   input  wire logic [7:0]                        reg_addr,
   input  wire logic [31:0]                       reg_wdata,
   input  wire logic                              reg_wr,
   input  wire logic                              reg_rd,
   output logic      [31:0]                       reg_rdata,
   output logic                                   irq,
   output logic                                   trig_out,
   output logic                                   acq_running
);
   import acq_pkg::*;

   typedef struct packed {
      acq_state_e        state;
      logic              clk_ext;
      logic              edge_fall;
      logic [1:0]        qual_mode;
      logic [3:0]        trig_en;
      logic [LVL_W-1:0]  thresh;
      logic [15:0]       div;
      logic [CH_N-1:0]   tval;
      logic [CH_N-1:0]   tcare;
      logic [CH_N-1:0]   tlo;
      logic [CH_N-1:0]   thi;
      logic [15:0]       tcount;
      logic [AW:0]       post;
      logic [AW-1:0]     mem_addr;
      logic [IRQ_W-1:0]  irq_stat;
      logic [IRQ_W-1:0]  irq_mask;
      logic [15:0]       div_cnt;
      logic [TS_W-1:0]   ts;
      logic [CH_N-1:0]   prev;
      logic [CH_N-1:0]   seen;
      logic [CH_N-1:0]   glitch;
      logic [15:0]       evt_cnt;
      logic [AW-1:0]     wptr;
      logic [AW-1:0]     trig_addr;
      logic              wrapped;
      logic [AW:0]       post_cnt;
      logic [31:0]       rdata;
      logic              irq;
      logic              trig_out;
      logic              running;
   } acq_s;

   acq_s r;
   acq_s next_r;

   logic [CH_N-1:0]  ch_bits;
   logic             tclk_edge;
   logic             sample_stb;
   logic             val_hit;
   logic             rng_hit;
   logic             ev_hit;
   logic             qual_hit;
   logic             trigger_now;
   logic             mem_we;
   logic [15:0]      cnt_next;
   logic [CH_N-1:0]  chg;
   logic [CH_N-1:0]  glitch_now;
   logic [31:0]      sample_word;
   logic [31:0]      mem [0:(1<<AW)-1];

   // Decides whether a sample is stored for the chosen qualifier mode.
   function automatic logic qual_fn(input logic [1:0] mode,
                                    input logic       vh,
                                    input logic       rh);
      unique case (mode)
         QUAL_ALL:  qual_fn = 1'b1;
         QUAL_VAL:  qual_fn = vh;
         QUAL_RNG:  qual_fn = rh;
         QUAL_NVAL: qual_fn = !vh;
      endcase
   endfunction

   input_conditioner #(
      .CH (CH_N),
      .LW (LVL_W)
   ) u_cond (
      .sys_clk   (sys_clk),
      .reset     (reset),
      .ch_level  (ch_level),
      .threshold (r.thresh),
      .tclk_pin  (tclk_pin),
      .edge_fall (r.edge_fall),
      .ch_bits   (ch_bits),
      .tclk_edge (tclk_edge)
   );

   // Sample clock source and the match terms seen by trigger and storage.
   always_comb begin
      sample_stb = r.clk_ext ? tclk_edge
                             : (r.div_cnt == r.div);
      val_hit  = ((ch_bits ^ r.tval) & r.tcare) == '0;
      rng_hit  = ch_bits >= r.tlo && ch_bits <= r.thi;
      ev_hit   = r.trig_en[2:0] == 3'h0 ||
                 (r.trig_en[TEN_VAL] && val_hit) ||
                 (r.trig_en[TEN_RNG] && rng_hit) ||
                 (r.trig_en[TEN_EXT] && ext_event);
      cnt_next = r.evt_cnt + 16'h0001;
      qual_hit = qual_fn(r.qual_mode, val_hit, rng_hit);
      trigger_now = r.state == ST_ARMED && sample_stb && ev_hit &&
                    (!r.trig_en[TEN_CNT] || cnt_next == r.tcount);
      mem_we   = r.running && sample_stb && qual_hit;
      chg        = ch_bits ^ r.prev;
      glitch_now = r.glitch | (r.seen & chg);
      sample_word = '0;
      sample_word[CH_N-1:0] = ch_bits;
      sample_word[SW_GLITCH +: CH_N] = r.clk_ext ? '0 : glitch_now;
      sample_word[SW_TS +: TS_W] = r.ts;
   end

   // Next state: acquisition first, then register writes, which may restart
   // it; the interrupt status is merged last so a set beats a clear.
   always_comb begin
      logic [IRQ_W-1:0] irq_set;
      logic [IRQ_W-1:0] irq_clr;
      logic [AW:0]      pc;
      logic [31:0]      rd;
      irq_set = '0;
      irq_clr = '0;
      pc      = r.post_cnt + 1'b1;
      rd      = '0;
      next_r  = r;
      next_r.ts       = r.ts + 1'b1;
      next_r.trig_out = 1'b0;
      next_r.prev     = ch_bits;
      next_r.div_cnt  = sample_stb ? 16'h0000 : r.div_cnt + 16'h0001;
      // Glitch means two or more changes between internal samples.
      if (sample_stb) begin
         next_r.seen   = '0;
         next_r.glitch = '0;
      end else begin
         next_r.seen   = r.seen | chg;
         next_r.glitch = glitch_now;
      end
      if (mem_we) begin
         next_r.wptr = r.wptr + 1'b1;
         if (r.wptr == '1) begin
            next_r.wrapped = 1'b1;
            irq_set[IRQ_WRAP] = !r.wrapped;
         end
      end
      unique case (r.state)
         ST_IDLE, ST_DONE: begin
         end
         ST_ARMED: begin
            if (sample_stb && ev_hit && r.trig_en[TEN_CNT]) begin
               next_r.evt_cnt = cnt_next;
            end
            if (trigger_now) begin
               next_r.trig_out  = 1'b1;
               next_r.trig_addr = r.wptr;
               next_r.post_cnt  = '0;
               irq_set[IRQ_TRIG] = 1'b1;
               if (r.post == '0) begin
                  next_r.state   = ST_DONE;
                  next_r.running = 1'b0;
                  irq_set[IRQ_DONE] = 1'b1;
               end else begin
                  next_r.state = ST_POST;
               end
            end
         end
         ST_POST: begin
            if (mem_we) begin
               next_r.post_cnt = pc;
               if (pc == r.post) begin
                  next_r.state   = ST_DONE;
                  next_r.running = 1'b0;
                  irq_set[IRQ_DONE] = 1'b1;
               end
            end
         end
      endcase
      // Register writes.
      if (reg_wr) begin
         case (reg_addr)
            OFF_CTRL: begin
               next_r.clk_ext   = reg_wdata[CTRL_EXT];
               next_r.edge_fall = reg_wdata[CTRL_FALL];
               next_r.qual_mode = reg_wdata[CTRL_QUAL +: 2];
               next_r.trig_en   = reg_wdata[CTRL_TEN +: 4];
               if (reg_wdata[CTRL_START]) begin
                  next_r.state    = ST_ARMED;
                  next_r.running  = 1'b1;
                  next_r.wptr     = '0;
                  next_r.wrapped  = 1'b0;
                  next_r.post_cnt = '0;
                  next_r.evt_cnt  = '0;
                  next_r.seen     = '0;
                  next_r.glitch   = '0;
                  next_r.div_cnt  = '0;
               end
            end
            OFF_THRESH:   next_r.thresh   = reg_wdata[LVL_W-1:0];
            OFF_DIV:      next_r.div      = reg_wdata[15:0];
            OFF_TVAL: begin
               next_r.tval  = reg_wdata[CH_N-1:0];
               next_r.tcare = reg_wdata[HI_FIELD +: CH_N];
            end
            OFF_TRANGE: begin
               next_r.tlo = reg_wdata[CH_N-1:0];
               next_r.thi = reg_wdata[HI_FIELD +: CH_N];
            end
            OFF_TCOUNT:   next_r.tcount   = reg_wdata[15:0];
            OFF_POST:     next_r.post     = reg_wdata[AW:0];
            OFF_IRQ_STAT: irq_clr         = reg_wdata[IRQ_W-1:0];
            OFF_IRQ_MASK: next_r.irq_mask = reg_wdata[IRQ_W-1:0];
            OFF_MEM_ADDR: next_r.mem_addr = reg_wdata[AW-1:0];
            default: begin
            end
         endcase
      end
      next_r.irq_stat = (r.irq_stat & ~irq_clr) | irq_set;
      next_r.irq      = |(next_r.irq_stat & next_r.irq_mask);
      // Register reads; data stands only in the cycle after the strobe.
      if (reg_rd) begin
         case (reg_addr)
            OFF_CTRL: begin
               rd[CTRL_EXT]        = r.clk_ext;
               rd[CTRL_FALL]       = r.edge_fall;
               rd[CTRL_QUAL +: 2]  = r.qual_mode;
               rd[CTRL_TEN +: 4]   = r.trig_en;
            end
            OFF_THRESH: rd[LVL_W-1:0] = r.thresh;
            OFF_DIV:    rd[15:0]      = r.div;
            OFF_TVAL: begin
               rd[CH_N-1:0]         = r.tval;
               rd[HI_FIELD +: CH_N] = r.tcare;
            end
            OFF_TRANGE: begin
               rd[CH_N-1:0]         = r.tlo;
               rd[HI_FIELD +: CH_N] = r.thi;
            end
            OFF_TCOUNT: rd[15:0] = r.tcount;
            OFF_POST:   rd[AW:0] = r.post;
            OFF_STATUS: begin
               rd[3:0]       = r.state;
               rd[STAT_WRAP] = r.wrapped;
            end
            OFF_PROGRESS: begin
               rd[AW-1:0]         = r.wptr;
               rd[PROG_POST +: AW+1] = r.post_cnt;
            end
            OFF_TRIGADDR: rd[AW-1:0]    = r.trig_addr;
            OFF_IRQ_STAT: rd[IRQ_W-1:0] = r.irq_stat;
            OFF_IRQ_MASK: rd[IRQ_W-1:0] = r.irq_mask;
            OFF_MEM_ADDR: rd[AW-1:0]    = r.mem_addr;
            OFF_MEM_DATA: rd            = mem[r.mem_addr];
            default:      rd            = '0;
         endcase
      end
      next_r.rdata = rd;
   end

   // State register with synchronous reset.
   always_ff @(posedge sys_clk) begin
      if (reset) begin
         r        <= '0;
         r.state  <= ST_IDLE;
         r.thresh <= THRESH_RST;
         r.div    <= DIV_RST;
         r.tcount <= TCOUNT_RST;
      end else begin
         r <= next_r;
      end
   end

   // Sample memory; unreset on purpose, its contents are only valid after a
   // run and a reset network on every word would cost far more than it buys.
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         mem[r.wptr] <= sample_word;
      end
   end

   assign reg_rdata   = r.rdata;
   assign irq         = r.irq;
   assign trig_out    = r.trig_out;
   assign acq_running = r.running;

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (reset);

   store_gate_a: assert property (
      !qual_hit || r.state == ST_IDLE || r.state == ST_DONE |-> !mem_we)
      else $error("Sample written while not qualified or not running.");

   wptr_step_a: assert property (
      mem_we && !reg_wr |=> r.wptr == $past(r.wptr) + 1'b1)
      else $error("Write pointer failed to advance after a store.");

   wrap_flag_a: assert property (
      mem_we && r.wptr == '1 && !reg_wr |=> r.wrapped)
      else $error("Memory wrap not flagged.");

   stop_count_a: assert property (
      (r.state != ST_DONE) ##1 (r.state == ST_DONE) |->
         r.post_cnt == $past(r.post) && !r.running)
      else $error("Acquisition stopped before the posttrigger count.");

   trig_post_a: assert property (
      trigger_now && !reg_wr |=> r.trig_out && r.state != ST_ARMED &&
         r.post_cnt == '0)
      else $error("Trigger did not start the posttrigger phase.");

   ext_clock_a: assert property (
      r.clk_ext && sample_stb |-> tclk_edge)
      else $error("External mode sampled without a target edge.");

   int_div_a: assert property (
      !r.clk_ext && !reg_wr && sample_stb |=> r.div_cnt == 16'h0000
         ##[1:2] 1'b1)
      else $error("Internal divider did not restart after a sample.");

   count_trig_a: assert property (
      trigger_now && r.trig_en[TEN_CNT] |-> r.evt_cnt + 16'h0001 == r.tcount)
      else $error("Counter trigger fired at the wrong count.");

   read_lat_a: assert property (
      reg_rd && reg_addr == OFF_PROGRESS |=>
         reg_rdata[AW-1:0] == $past(r.wptr))
      else $error("Progress read returned stale pointer.");

   irq_level_a: assert property (
      r.irq_stat[IRQ_DONE] && r.irq_mask[IRQ_DONE] |-> irq)
      else $error("Unmasked done status without interrupt.");

   trig_seen_c: cover property (trigger_now);
   done_seen_c: cover property (r.state == ST_POST ##1 r.state == ST_DONE);
   wrap_seen_c: cover property (mem_we && r.wptr == '1);
   glitch_c:    cover property (mem_we && sample_word[SW_GLITCH +: CH_N] != '0);

endmodule
